// ### logic/nand_read_program_sequencer.sv
// Host sequencer driving page read, cache read, multi read and program
`timescale 1ns/1ps
`default_nettype none
module nand_read_program_sequencer (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Operation requests
  input wire logic req_valid_i,
  input wire nand_host_pkg::req_t req_i,
  output logic req_ready_o,
  output logic req_err_o,
  output logic op_done_o,
  // Program data stream
  input wire logic wr_valid_i,
  input wire nand_host_pkg::wr_t wr_i,
  output logic wr_ready_o,
  // Read data stream
  output logic rd_valid_o,
  output logic [7:0] rd_data_o,
  input wire logic rd_ready_i,
  // Protection request
  input wire logic wp_protect_i,
  // Flash pins
  output nand_host_pkg::pins_t pins_o,
  input wire logic [7:0] io_i,
  input wire logic ready_busy_i
);

  typedef enum logic [3:0] {
    ST_IDLE, ST_CMD1, ST_ADDR, ST_DIN, ST_JCMD, ST_CMD2, ST_WAIT,
    ST_BUSY, ST_DOUT
  } state_t;

  localparam int RW = nand_host_pkg::ROW_W;
  localparam int CW = nand_host_pkg::COL_W;
  localparam int PW = nand_host_pkg::PIB_W;
  localparam int BT = nand_host_pkg::BLK_TOP;

  //------------------------------------------------------------------
  // Helpers
  //------------------------------------------------------------------
  // Byte of the five-cycle address
  function automatic logic [7:0] addr_byte(input logic [CW-1:0] col,
      input logic [RW-1:0] row, input logic [2:0] idx);
    unique case (idx)
      3'h0: addr_byte = col[7:0];
      3'h1: addr_byte = {3'h0, col[CW-1:8]};
      3'h2: addr_byte = row[7:0];
      3'h3: addr_byte = row[15:8];
      default: addr_byte = {6'h00, row[RW-1:16]};
    endcase
  endfunction : addr_byte

  // District pair check for multi read
  function automatic logic pair_ok(input logic [RW-1:0] r1,
      input logic [RW-1:0] r2);
    pair_ok = (r1[PW] != r2[PW])
      && (r1[BT] == r2[BT])
      && (r1[PW-1:0] == r2[PW-1:0]);
  endfunction : pair_ok

  //------------------------------------------------------------------
  // State
  //------------------------------------------------------------------
  state_t st_ff, nxt_st;
  nand_host_pkg::op_t op_ff, nxt_op;
  logic [RW-1:0] row_ff, nxt_row, row2_ff, nxt_row2, open_row_ff;
  logic [RW-1:0] nxt_open_row;
  logic [CW-1:0] col_ff, nxt_col;
  logic [nand_host_pkg::LEN_W-1:0] len_ff, nxt_len;
  logic [2:0] cnt_ff, nxt_cnt, addr_last;
  logic [3:0] wait_ff, nxt_wait;
  logic second_ff, nxt_second, jump_ff, nxt_jump, open_ff, nxt_open;
  logic multi_ff, nxt_multi, pend_ff, nxt_pend, err_ff, nxt_err;
  logic done_ff, nxt_done, rdv_ff, nxt_rdv, wp_n_ff, ce_n_ff;
  logic [7:0] rdd_ff, nxt_rdd;
  logic go, legal;
  nand_host_pkg::cyc_t cyc;
  logic eng_ready, eng_done, eng_cle, eng_ale, eng_we_n, eng_re_n;
  logic eng_oe_n;
  logic [7:0] eng_io, eng_rdata;

  // Whether a request may be sent now
  always_comb begin
    legal = 1'b1;
    unique case (req_i.op)
      // Next page must stay inside the block or pair
      nand_host_pkg::OP_CACHE:
        legal = open_ff && (open_row_ff[PW-1:0] != '1);
      nand_host_pkg::OP_LAST: legal = open_ff;
      nand_host_pkg::OP_MULTI: legal = pair_ok(req_i.row, req_i.row2);
      default: legal = 1'b1;
    endcase
  end

  assign addr_last = (op_ff == nand_host_pkg::OP_OUT_COL || jump_ff) ?
    nand_host_pkg::ADDR_LAST_COL : nand_host_pkg::ADDR_LAST_FULL;

  //------------------------------------------------------------------
  // Sequencer
  //------------------------------------------------------------------
  // Next state of the command sequencer
  always_comb begin
    nxt_st = st_ff;
    nxt_op = op_ff;
    nxt_row = row_ff;
    nxt_row2 = row2_ff;
    nxt_col = col_ff;
    nxt_len = len_ff;
    nxt_cnt = cnt_ff;
    nxt_wait = wait_ff;
    nxt_second = second_ff;
    nxt_jump = jump_ff;
    nxt_open = open_ff;
    nxt_open_row = open_row_ff;
    nxt_multi = multi_ff;
    nxt_pend = pend_ff;
    nxt_err = 1'b0;
    nxt_done = 1'b0;
    nxt_rdv = rdv_ff;
    nxt_rdd = rdd_ff;
    go = 1'b0;
    wr_ready_o = 1'b0;
    cyc = '{kind: nand_host_pkg::CY_CMD, data: 8'h00};
    unique case (st_ff)
      ST_IDLE: begin
        if (req_valid_i && !legal) nxt_err = 1'b1;
        if (req_valid_i && legal) begin
          nxt_op = req_i.op;
          nxt_row = req_i.row;
          nxt_row2 = req_i.row2;
          nxt_col = req_i.col;
          nxt_len = req_i.len;
          nxt_cnt = 3'h0;
          nxt_second = 1'b0;
          nxt_jump = 1'b0;
          nxt_st = (req_i.op == nand_host_pkg::OP_DOUT) ? ST_DOUT : ST_CMD1;
          unique case (req_i.op)
            nand_host_pkg::OP_READ, nand_host_pkg::OP_MULTI: begin
              nxt_open = 1'b1;
              nxt_open_row = req_i.row;
              nxt_multi = (req_i.op == nand_host_pkg::OP_MULTI);
            end
            nand_host_pkg::OP_CACHE: nxt_open_row = open_row_ff + 18'h1;
            nand_host_pkg::OP_LAST, nand_host_pkg::OP_PROG:
              nxt_open = 1'b0;
            default: nxt_open = open_ff;
          endcase
        end
      end
      ST_CMD1: begin
        unique case (op_ff)
          nand_host_pkg::OP_READ: cyc.data = nand_host_pkg::OPC_READ_SETUP;
          nand_host_pkg::OP_CACHE: cyc.data = nand_host_pkg::OPC_CACHE_NEXT;
          nand_host_pkg::OP_LAST: cyc.data = nand_host_pkg::OPC_CACHE_LAST;
          nand_host_pkg::OP_MULTI: cyc.data = nand_host_pkg::OPC_DISTRICT;
          nand_host_pkg::OP_PROG:
            cyc.data = nand_host_pkg::OPC_PROG_SETUP;
          default: cyc.data = nand_host_pkg::OPC_OUT_COL;
        endcase
        go = eng_ready;
        if (go) begin
          // Multi read sends row cycles only
          nxt_cnt = (op_ff == nand_host_pkg::OP_MULTI) ?
            nand_host_pkg::ADDR_FIRST_ROW : 3'h0;
          nxt_wait = 4'h0;
          nxt_st = (op_ff == nand_host_pkg::OP_CACHE ||
            op_ff == nand_host_pkg::OP_LAST) ? ST_WAIT : ST_ADDR;
        end
      end
      ST_ADDR: begin
        cyc.kind = nand_host_pkg::CY_ADDR;
        cyc.data = addr_byte(col_ff, second_ff ? row2_ff : row_ff, cnt_ff);
        go = eng_ready;
        if (go) begin
          nxt_cnt = cnt_ff + 3'h1;
          if (cnt_ff == addr_last) begin
            nxt_cnt = 3'h0;
            if (op_ff == nand_host_pkg::OP_PROG) begin
              nxt_st = ST_DIN;
            end else if (op_ff == nand_host_pkg::OP_MULTI && !second_ff)
                begin
              nxt_second = 1'b1;
              nxt_st = ST_CMD1;
            end else begin
              nxt_st = ST_CMD2;
            end
          end
        end
      end
      ST_DIN: begin
        cyc.kind = nand_host_pkg::CY_DIN;
        cyc.data = wr_i.data;
        if (wr_valid_i && wr_i.jump && !jump_ff) begin
          nxt_col = wr_i.jcol;
          nxt_st = ST_JCMD;
        end else if (wr_valid_i) begin
          go = eng_ready;
          wr_ready_o = eng_ready;
          if (go) begin
            nxt_jump = 1'b0;
            if (wr_i.last) nxt_st = ST_CMD2;
          end
        end
      end
      ST_JCMD: begin
        cyc.data = nand_host_pkg::OPC_PROG_COL;
        go = eng_ready;
        if (go) begin
          nxt_jump = 1'b1;
          nxt_cnt = 3'h0;
          nxt_st = ST_ADDR;
        end
      end
      ST_CMD2: begin
        unique case (op_ff)
          nand_host_pkg::OP_PROG: cyc.data = nand_host_pkg::OPC_PROG_GO;
          nand_host_pkg::OP_OUT_COL:
            cyc.data = nand_host_pkg::OPC_OUT_COL_GO;
          default: cyc.data = nand_host_pkg::OPC_READ_GO;
        endcase
        go = eng_ready;
        if (go) begin
          nxt_wait = 4'h0;
          nxt_st = ST_WAIT;
        end
      end
      ST_WAIT: begin
        // Let busy assert before polling it
        if (eng_ready) begin
          nxt_wait = wait_ff + 4'h1;
          if (wait_ff == nand_host_pkg::WB_CYC - 4'h1) begin
            nxt_st = (op_ff == nand_host_pkg::OP_OUT_COL) ? ST_IDLE :
              ST_BUSY;
            nxt_done = (op_ff == nand_host_pkg::OP_OUT_COL);
          end
        end
      end
      ST_BUSY: begin
        // No strobes until ready returns
        if (ready_busy_i) begin
          nxt_st = ST_IDLE;
          nxt_done = 1'b1;
          nxt_multi = 1'b0;
        end
      end
      ST_DOUT: begin
        cyc.kind = nand_host_pkg::CY_DOUT;
        if (rdv_ff && rd_ready_i) nxt_rdv = 1'b0;
        go = eng_ready && !pend_ff && !rdv_ff && (len_ff != '0);
        if (go) begin
          nxt_pend = 1'b1;
          nxt_len = len_ff - 13'h1;
        end
        if (eng_done && pend_ff) begin
          nxt_pend = 1'b0;
          nxt_rdv = 1'b1;
          nxt_rdd = eng_rdata;
        end
        if (!pend_ff && !rdv_ff && len_ff == '0) begin
          nxt_st = ST_IDLE;
          nxt_done = 1'b1;
        end
      end
      default: nxt_st = ST_IDLE;
    endcase
  end

  // Sequencer registers
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      st_ff <= ST_IDLE;
      op_ff <= nand_host_pkg::OP_READ;
      row_ff <= '0;
      row2_ff <= '0;
      col_ff <= '0;
      len_ff <= '0;
      cnt_ff <= 3'h0;
      wait_ff <= 4'h0;
      second_ff <= 1'b0;
      jump_ff <= 1'b0;
      open_ff <= 1'b0;
      open_row_ff <= '0;
      multi_ff <= 1'b0;
      pend_ff <= 1'b0;
      err_ff <= 1'b0;
      done_ff <= 1'b0;
      rdv_ff <= 1'b0;
      rdd_ff <= 8'h00;
      wp_n_ff <= 1'b0;
      ce_n_ff <= 1'b1;
    end else begin
      st_ff <= nxt_st;
      op_ff <= nxt_op;
      row_ff <= nxt_row;
      row2_ff <= nxt_row2;
      col_ff <= nxt_col;
      len_ff <= nxt_len;
      cnt_ff <= nxt_cnt;
      wait_ff <= nxt_wait;
      second_ff <= nxt_second;
      jump_ff <= nxt_jump;
      open_ff <= nxt_open;
      open_row_ff <= nxt_open_row;
      multi_ff <= nxt_multi;
      pend_ff <= nxt_pend;
      err_ff <= nxt_err;
      done_ff <= nxt_done;
      rdv_ff <= nxt_rdv;
      rdd_ff <= nxt_rdd;
      wp_n_ff <= !wp_protect_i || nxt_multi;
      ce_n_ff <= (nxt_st == ST_IDLE);
    end
  end

  //------------------------------------------------------------------
  // Pin engine and outputs
  //------------------------------------------------------------------
  strobe_cycle_engine u_engine (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .go_i(go),
    .cyc_i(cyc),
    .ready_o(eng_ready),
    .done_o(eng_done),
    .io_i(io_i),
    .cle_o(eng_cle),
    .ale_o(eng_ale),
    .we_n_o(eng_we_n),
    .re_n_o(eng_re_n),
    .io_o(eng_io),
    .io_oe_n_o(eng_oe_n),
    .rdata_o(eng_rdata)
  );

  assign pins_o = '{cle: eng_cle, ale: eng_ale, ce_n: ce_n_ff,
    we_n: eng_we_n, re_n: eng_re_n, wp_n: wp_n_ff, io: eng_io,
    io_oe_n: eng_oe_n};
  assign req_ready_o = (st_ff == ST_IDLE);
  assign req_err_o = err_ff;
  assign op_done_o = done_ff;
  assign rd_valid_o = rdv_ff;
  assign rd_data_o = rdd_ff;

  //------------------------------------------------------------------
  // Assertions
  //------------------------------------------------------------------
  pair_range_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    (st_ff == ST_CMD1 && op_ff == nand_host_pkg::OP_MULTI)
    |-> (row_ff[BT] == row2_ff[BT]) && (row_ff[PW] != row2_ff[PW]))
    else $error("multi read pair crosses ranges or districts");

  page_match_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    (st_ff == ST_ADDR && op_ff == nand_host_pkg::OP_MULTI && go)
    |-> row_ff[PW-1:0] == row2_ff[PW-1:0])
    else $error("multi read page bits differ");

  wp_hold_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    (st_ff != ST_IDLE && op_ff == nand_host_pkg::OP_MULTI) |-> pins_o.wp_n)
    else $error("write protect low during multi read");

  addr_five_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    ($rose(st_ff == ST_CMD2) && op_ff == nand_host_pkg::OP_READ)
    |-> $past(cnt_ff) == nand_host_pkg::ADDR_LAST_FULL)
    else $error("read confirm not after five address cycles");

  cache_block_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    (st_ff == ST_IDLE && req_valid_i && req_i.op == nand_host_pkg::OP_CACHE
      && open_row_ff[PW-1:0] == '1) |=> req_err_o && st_ff == ST_IDLE)
    else $error("cache read allowed across block end");

  prog_confirm_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    (st_ff == ST_CMD2 && op_ff == nand_host_pkg::OP_PROG && go)
    |-> cyc.data == nand_host_pkg::OPC_PROG_GO ##1 st_ff == ST_WAIT)
    else $error("program not confirmed with program opcode");

  col_change_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    (st_ff == ST_JCMD && go) |=> st_ff == ST_ADDR && jump_ff
      && cnt_ff == 3'h0)
    else $error("column change not followed by column cycles");

  busy_wait_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    (st_ff == ST_BUSY && !ready_busy_i) |=> st_ff == ST_BUSY && !go)
    else $error("sequencer left busy wait early");

  rd_hold_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    (rd_valid_o && !rd_ready_i) |=> rd_valid_o && $stable(rd_data_o))
    else $error("read byte lost under back-pressure");

endmodule : nand_read_program_sequencer
`default_nettype wire

// ### logic/nand_host_pkg.sv
// Package: constants, opcodes and carriers of the flash host sequencer
//------------------------------------------------------------------
// Contract
//------------------------------------------------------------------
// Contract
// - Page read: 00h, five address cycles, 30h
// - Cached reads stay in one block; else restart
// - After ready, 31h copies buffer to cache
// - Multi cached read stays in one block pair
// - Pair lower with lower, upper with upper ranges
// - At most one block from each district
// - Both districts use same page-in-block bits
// - 60h addr, 60h addr, 30h; any district order
// - Write protect held high during multi read
// - Column change repeats; 10h programs whole page
// - Five address cycles, 13 column, 18 row bits
// - Program sequence opens with 80h
// - Output column change: 05h, two columns, E0h
package nand_host_pkg;

  //------------------------------------------------------------------
  // Opcodes
  //------------------------------------------------------------------
  localparam logic [7:0] OPC_READ_SETUP = 8'h00;
  localparam logic [7:0] OPC_READ_GO = 8'h30;
  localparam logic [7:0] OPC_CACHE_NEXT = 8'h31;
  localparam logic [7:0] OPC_CACHE_LAST = 8'h3F;
  localparam logic [7:0] OPC_DISTRICT = 8'h60;
  localparam logic [7:0] OPC_PROG_SETUP = 8'h80;
  localparam logic [7:0] OPC_PROG_GO = 8'h10;
  localparam logic [7:0] OPC_PROG_COL = 8'h85;
  localparam logic [7:0] OPC_OUT_COL = 8'h05;
  localparam logic [7:0] OPC_OUT_COL_GO = 8'hE0;

  //------------------------------------------------------------------
  // Address layout
  //------------------------------------------------------------------
  localparam int COL_W = 13;
  localparam int ROW_W = 18;
  localparam int PIB_W = 6;
  localparam int LEN_W = 13;
  localparam int BLK_TOP = 17;
  localparam logic [2:0] ADDR_LAST_FULL = 3'h4;
  localparam logic [2:0] ADDR_LAST_COL = 3'h1;
  localparam logic [2:0] ADDR_FIRST_ROW = 3'h2;

  //------------------------------------------------------------------
  // Timing
  //------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int WB_TIME_NS = 100;
  localparam logic [3:0] WB_CYC =
    4'((WB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  //------------------------------------------------------------------
  // Types
  //------------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_READ, OP_CACHE, OP_LAST, OP_MULTI, OP_PROG, OP_OUT_COL, OP_DOUT
  } op_t;

  typedef enum logic [1:0] {CY_CMD, CY_ADDR, CY_DIN, CY_DOUT} cyc_kind_t;

  typedef struct packed {
    op_t op;
    logic [ROW_W-1:0] row;
    logic [ROW_W-1:0] row2;
    logic [COL_W-1:0] col;
    logic [LEN_W-1:0] len;
  } req_t;

  typedef struct packed {
    logic [7:0] data;
    logic jump;
    logic [COL_W-1:0] jcol;
    logic last;
  } wr_t;

  typedef struct packed {
    cyc_kind_t kind;
    logic [7:0] data;
  } cyc_t;

  typedef struct packed {
    logic cle;
    logic ale;
    logic ce_n;
    logic we_n;
    logic re_n;
    logic wp_n;
    logic [7:0] io;
    logic io_oe_n;
  } pins_t;

endpackage : nand_host_pkg

// ### logic/strobe_cycle_engine.sv
// One write or read strobe cycle on the flash pins
`timescale 1ns/1ps
`default_nettype none
module strobe_cycle_engine (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Cycle request
  input wire logic go_i,
  input wire nand_host_pkg::cyc_t cyc_i,
  output logic ready_o,
  output logic done_o,
  // Pin side
  input wire logic [7:0] io_i,
  output logic cle_o,
  output logic ale_o,
  output logic we_n_o,
  output logic re_n_o,
  output logic [7:0] io_o,
  output logic io_oe_n_o,
  output logic [7:0] rdata_o
);

  typedef enum logic [1:0] {EG_IDLE, EG_LOW, EG_HIGH} eg_state_t;

  eg_state_t st_ff, nxt_st;
  logic cle_ff, nxt_cle, ale_ff, nxt_ale, we_n_ff, nxt_we_n;
  logic re_n_ff, nxt_re_n, oe_n_ff, nxt_oe_n;
  logic [7:0] io_ff, nxt_io, rdata_ff, nxt_rdata;

  // Strobe low one clock, high one clock, then hold
  always_comb begin
    nxt_st = st_ff;
    nxt_cle = cle_ff;
    nxt_ale = ale_ff;
    nxt_we_n = 1'b1;
    nxt_re_n = 1'b1;
    nxt_io = io_ff;
    nxt_oe_n = oe_n_ff;
    nxt_rdata = rdata_ff;
    unique case (st_ff)
      EG_IDLE: begin
        nxt_cle = 1'b0;
        nxt_ale = 1'b0;
        nxt_oe_n = 1'b1;
        if (go_i) begin
          nxt_cle = (cyc_i.kind == nand_host_pkg::CY_CMD);
          nxt_ale = (cyc_i.kind == nand_host_pkg::CY_ADDR);
          nxt_io = cyc_i.data;
          nxt_oe_n = (cyc_i.kind == nand_host_pkg::CY_DOUT);
          nxt_we_n = (cyc_i.kind == nand_host_pkg::CY_DOUT);
          nxt_re_n = (cyc_i.kind != nand_host_pkg::CY_DOUT);
          nxt_st = EG_LOW;
        end
      end
      EG_LOW: begin
        // Data valid after falling read strobe
        if (!re_n_ff) nxt_rdata = io_i;
        nxt_st = EG_HIGH;
      end
      EG_HIGH: nxt_st = EG_IDLE;
      default: nxt_st = EG_IDLE;
    endcase
  end

  // State registers
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      st_ff <= EG_IDLE;
      cle_ff <= 1'b0;
      ale_ff <= 1'b0;
      we_n_ff <= 1'b1;
      re_n_ff <= 1'b1;
      io_ff <= 8'h00;
      oe_n_ff <= 1'b1;
      rdata_ff <= 8'h00;
    end else begin
      st_ff <= nxt_st;
      cle_ff <= nxt_cle;
      ale_ff <= nxt_ale;
      we_n_ff <= nxt_we_n;
      re_n_ff <= nxt_re_n;
      io_ff <= nxt_io;
      oe_n_ff <= nxt_oe_n;
      rdata_ff <= nxt_rdata;
    end
  end

  assign ready_o = (st_ff == EG_IDLE);
  assign done_o = (st_ff == EG_HIGH);
  assign cle_o = cle_ff;
  assign ale_o = ale_ff;
  assign we_n_o = we_n_ff;
  assign re_n_o = re_n_ff;
  assign io_o = io_ff;
  assign io_oe_n_o = oe_n_ff;
  assign rdata_o = rdata_ff;

  // Every write strobe low lasts exactly one clock, data held
  strobe_pulse_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    $fell(we_n_ff) |=> $rose(we_n_ff) && $stable(io_ff) ##1 $stable(io_ff))
    else $error("write strobe low not one clock or data moved");

endmodule : strobe_cycle_engine
`default_nettype wire

// ### test/nand_flash_model.sv
// Behavioural flash device answering the host sequencer
`timescale 1ns/1ps
`default_nettype none
module nand_flash_model (
  // Pins from the host
  input wire nand_host_pkg::pins_t p_i,
  input wire logic [31:0] busy_ns_i,
  // Pins to the host
  output logic [7:0] io_o,
  output logic ready_busy_o,
  // Observation
  output logic fault_o,
  output logic [17:0] dist0_o,
  output logic [17:0] dist1_o
);
  logic [7:0] cmd = 8'h00;
  logic [12:0] col;
  logic [17:0] row;
  int acnt;
  logic multi = 1'b0;
  logic [7:0] mem [logic [30:0]];
  initial fault_o = 1'b0;
  initial ready_busy_o = 1'b1;

  // Busy window after a confirm opcode
  task automatic go_busy();
    ready_busy_o = 1'b0;
    ready_busy_o <= #(busy_ns_i) 1'b1;
  endtask : go_busy

  // Latch command, address and data on the write strobe
  always @(posedge p_i.we_n) begin
    if (p_i.ce_n === 1'b0 && ready_busy_o === 1'b1) begin
      if (p_i.io_oe_n !== 1'b0) fault_o = 1'b1;
      if (p_i.cle === 1'b1) begin
        cmd = p_i.io;
        acnt = (cmd == 8'h60) ? 2 : 0;
        if (cmd == 8'h60) multi = 1'b1;
        if (cmd == 8'h31 || cmd == 8'h3F) begin
          row = row + 18'h1;
          col = '0;
        end
        if (cmd inside {8'h30, 8'h31, 8'h3F, 8'h10}) go_busy();
      end else if (p_i.ale === 1'b1) begin
        case (acnt)
          0: col[7:0] = p_i.io;
          1: col[12:8] = p_i.io[4:0];
          2: row[7:0] = p_i.io;
          3: row[15:8] = p_i.io;
          default: row[17:16] = p_i.io[1:0];
        endcase
        if (acnt == 1 && p_i.io[7:5] != 0) fault_o = 1'b1;
        if (acnt == 4 && p_i.io[7:2] != 0) fault_o = 1'b1;
        if (acnt == 4 && cmd == 8'h60 && !row[6]) dist0_o = row;
        if (acnt == 4 && cmd == 8'h60 && row[6]) dist1_o = row;
        acnt++;
      end else begin
        mem[{row, col}] = p_i.io;
        col = col + 13'h1;
      end
    end
  end

  // Byte on each falling read strobe; released bus shows its inverse
  always @(p_i.re_n) begin
    if (p_i.re_n === 1'b1) begin
      io_o = ~io_o;
    end else if (p_i.ce_n === 1'b0 && ready_busy_o === 1'b1) begin
      io_o = mem.exists({row, col}) ? mem[{row, col}] :
        row[7:0] ^ col[7:0] ^ 8'h5A;
      col = col + 13'h1;
    end
  end

  // Protect must stay off until a multi read is ready
  always @(posedge ready_busy_o) multi = 1'b0;
  always @(p_i.wp_n, multi) if (multi && p_i.wp_n !== 1'b1) fault_o = 1'b1;
endmodule : nand_flash_model
`default_nettype wire

// ### test/nand_read_program_sequencer_bench.sv
// Self-checking bench for the flash host sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin \
  bad_count++; $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module nand_read_program_sequencer_bench;
  // Ports and bench state
  logic clk_i, sys_rst_i, req_valid_i, req_ready_o, req_err_o, op_done_o;
  logic wr_valid_i, wr_ready_o, rd_valid_o, rd_ready_i, wp_protect_i;
  logic ready_busy_i, fault, err_seen;
  logic [7:0] rd_data_o, io_i;
  logic [17:0] dist0, dist1;
  logic [31:0] busy_ns;
  nand_host_pkg::req_t req_i;
  nand_host_pkg::wr_t wr_i;
  nand_host_pkg::wr_t wq[$];
  nand_host_pkg::pins_t pins_o;
  logic [7:0] rq[$];
  int bad_count = 0;
  int total_checks = 0;
  int cycles = 0;

  nand_read_program_sequencer u_nand_read_program_sequencer (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .req_valid_i(req_valid_i),
    .req_i(req_i), .req_ready_o(req_ready_o), .req_err_o(req_err_o),
    .op_done_o(op_done_o), .wr_valid_i(wr_valid_i), .wr_i(wr_i),
    .wr_ready_o(wr_ready_o), .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o),
    .rd_ready_i(rd_ready_i), .wp_protect_i(wp_protect_i), .pins_o(pins_o),
    .io_i(io_i), .ready_busy_i(ready_busy_i));
  nand_flash_model u_nand_flash_model (.p_i(pins_o), .busy_ns_i(busy_ns),
    .io_o(io_i), .ready_busy_o(ready_busy_i), .fault_o(fault),
    .dist0_o(dist0), .dist1_o(dist1));

  // Clock and hang guard
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 30000) begin
      bad_count++;
      results();
    end
  end

  // Counts and verdict
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results

  // One request run to its end, streaming bytes both ways
  task automatic run(input nand_host_pkg::op_t op, input logic [17:0] r,
      input logic [17:0] r2, input logic [12:0] c, input logic [12:0] l);
    logic took, fin;
    @(posedge clk_i);
    #1 req_i = '{op, r, r2, c, l};
    req_valid_i = 1'b1;
    @(posedge clk_i);
    #1 req_valid_i = 1'b0;
    rq = {};
    repeat (2000) begin
      err_seen = req_err_o;
      fin = op_done_o === 1'b1 || req_err_o === 1'b1;
      if (fin) break;
      // Back-pressure on every other cycle; a byte counts once taken
      rd_ready_i = !rd_ready_i;
      if (rd_valid_o === 1'b1 && rd_ready_i) rq.push_back(rd_data_o);
      wr_valid_i = wq.size() > 0;
      if (wq.size() > 0) wr_i = wq[0];
      #1 took = wr_valid_i && wr_ready_o === 1'b1;
      @(posedge clk_i);
      #1 if (took) void'(wq.pop_front());
    end
    // A request that never ends is a mismatch
    if (!fin) begin
      bad_count++;
      results();
    end
    `CHK("idle", 1'b1, req_ready_o)
  endtask : run

  // Read n bytes, compare with the device pattern
  task automatic dout(input logic [17:0] r, input logic [12:0] c, input int n);
    run(nand_host_pkg::OP_DOUT, '0, '0, '0, 13'(n));
    `CHK("count", n, rq.size())
    for (int i = 0; i < n; i++) `CHK("byte", r[7:0]^8'(c+i)^8'h5A, rq[i])
  endtask : dout

  // Page read up to the last column, prompt and slow busy
  task automatic t_read();
    for (int k = 0; k < 2; k++) begin
      busy_ns = k ? 32'd3000 : 32'd300;
      run(nand_host_pkg::OP_READ, 18'h00483 + 18'(k), '0, 13'h10FE, '0);
      `CHK("read_err", 1'b0, err_seen)
      dout(18'h00483 + 18'(k), 13'h10FE, 2);
    end
  endtask : t_read

  // Cache chain closed by the last-page opcode, then refused
  task automatic t_cache();
    run(nand_host_pkg::OP_READ, 18'h00A00, '0, '0, '0);
    for (int k = 1; k < 4; k++) begin
      run(k < 3 ? nand_host_pkg::OP_CACHE : nand_host_pkg::OP_LAST,
        '0, '0, '0, '0);
      `CHK("cache_err", 1'b0, err_seen)
      dout(18'h00A00 + 18'(k), '0, 2);
    end
    run(nand_host_pkg::OP_CACHE, '0, '0, '0, '0);
    `CHK("closed", 1'b1, err_seen)
  endtask : t_cache

  // Refusals: no open read, page leaving block, bad pairs
  task automatic t_refuse();
    logic [17:0] bad2 [3] = '{18'h00105, 18'h20145, 18'h00146};
    run(nand_host_pkg::OP_LAST, '0, '0, '0, '0);
    `CHK("no_read", 1'b1, err_seen)
    run(nand_host_pkg::OP_READ, 18'h0013F, '0, '0, '0);
    run(nand_host_pkg::OP_CACHE, '0, '0, '0, '0);
    `CHK("blk_end", 1'b1, err_seen)
    for (int i = 0; i < 3; i++) begin
      run(nand_host_pkg::OP_MULTI, 18'h00105, bad2[i], '0, '0);
      `CHK("pair", 1'b1, err_seen)
    end
  endtask : t_refuse

  // Multi read in both district orders with protect requested
  task automatic t_multi();
    logic [17:0] a, b;
    wp_protect_i = 1'b1;
    for (int k = 0; k < 2; k++) begin
      a = 18'h00105 + 18'(k);
      b = 18'h0FFC5 + 18'(k);
      run(nand_host_pkg::OP_MULTI, k ? b : a, k ? a : b, '0, '0);
      `CHK("multi_err", 1'b0, err_seen)
      `CHK("dist0", a, dist0)
      `CHK("dist1", b, dist1)
    end
    `CHK("wp_idle", 1'b0, pins_o.wp_n)
  endtask : t_multi

  // Program with a column jump, read back through a column change
  task automatic t_prog();
    wp_protect_i = 1'b0;
    wq = '{'{8'h11, 1'b0, 13'h0, 1'b0}, '{8'h22, 1'b0, 13'h0, 1'b0},
      '{8'h33, 1'b1, 13'h0C8, 1'b1}};
    run(nand_host_pkg::OP_PROG, 18'h02345, '0, 13'h0014, '0);
    `CHK("prog_err", 1'b0, err_seen)
    `CHK("wr_left", 0, wq.size())
    run(nand_host_pkg::OP_READ, 18'h02345, '0, 13'h0014, '0);
    run(nand_host_pkg::OP_DOUT, '0, '0, '0, 13'h0002);
    `CHK("prog0", 8'h11, rq[0])
    `CHK("prog1", 8'h22, rq[1])
    run(nand_host_pkg::OP_OUT_COL, '0, '0, 13'h0C8, '0);
    run(nand_host_pkg::OP_DOUT, '0, '0, '0, 13'h0001);
    `CHK("jump", 8'h33, rq[0])
  endtask : t_prog

  // Main sequence
  initial begin
    sys_rst_i = 1'b1;
    req_valid_i = 1'b0;
    req_i = '0;
    wr_valid_i = 1'b0;
    wr_i = '0;
    rd_ready_i = 1'b1;
    wp_protect_i = 1'b0;
    busy_ns = 32'd300;
    repeat (16) @(posedge clk_i);
    #1 sys_rst_i = 1'b0;
    t_read();
    t_cache();
    t_refuse();
    t_multi();
    t_prog();
    `CHK("fault", 1'b0, fault)
    results();
  end
endmodule : nand_read_program_sequencer_bench
`default_nettype wire
